// ==== logic/port_pin_sharing_mux.sv ====
// Port pin sharing mux with AXI4-Lite port registers and external interrupt pin
// How it works
// - Interrupt pin enabled for rising edges gets a pulldown instead of pullup.
// - After reset every pin is a floating input with pull devices off.
// - Port read value follows direction bit, not the owning peripheral's direction.
// - An owning peripheral sets pin direction through the output buffer enable.
// - Pullup enable turns on pull device whenever pin is input, any owner.
// - Port D bits 7,3,2, port G bit 4: rising key sense gives pulldown while the first alternate owns the pin.
// - Only the highest priority enabled module drives a shared pin.
// - Priority: port lowest, first alternate, second alternate highest.
// - Interrupt pin detects nothing while disabled, though its pullup still works; its level still reads back at OFS_IRQ_STAT.
`timescale 1ns/1ns
module port_pin_sharing_mux
  import pin_mux_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pin_mux_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [pin_mux_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_in,
  output logic [pin_mux_pkg::NUM_PINS-1:0]  pin_oe,
  output logic [pin_mux_pkg::NUM_PINS-1:0]  pin_out,
  output logic [pin_mux_pkg::NUM_PINS-1:0]  pin_pull_up,
  output logic [pin_mux_pkg::NUM_PINS-1:0]  pin_pull_dn,
  output logic [pin_mux_pkg::NUM_PINS-1:0]  pin_level,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt1_en,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt1_oe,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt1_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_en,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_oe,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] key_interrupt_rise,
  input  wire logic                         ext_irq_pin,
  output logic                              ext_irq_pull_up,
  output logic                              ext_irq_pull_dn,
  output logic                              ext_irq_asserted,
  output logic                              ext_irq_edge
);
  import pin_mux_pkg::*;

  // Port registers, flat: port p owns bits p*PORT_W +: PORT_W
  logic [NUM_PINS-1:0] data_q, data_d;
  logic [NUM_PINS-1:0] dir_q, dir_d;
  logic [NUM_PINS-1:0] pull_q, pull_d;
  logic [2:0]          irq_ctrl_q, irq_ctrl_d;
  // Pin and interrupt pin synchronisers, and what a port read shows
  logic [NUM_PINS-1:0] pin_meta_q, pin_sync_q, port_view;
  logic                irq_meta_q, irq_sync_q, irq_prev_q;
  // Bus state
  logic                aw_held_q, aw_held_d;
  logic [ADDR_W-1:0]   aw_addr_q, aw_addr_d;
  logic                w_held_q, w_held_d;
  logic [7:0]          w_byte_q, w_byte_d;
  logic                w_lane_q, w_lane_d;
  logic                bvalid_q, bvalid_d;
  logic [1:0]          bresp_q, bresp_d;
  logic                awready_q, awready_d, wready_q, wready_d;
  logic                arready_q, arready_d;
  logic                rvalid_q, rvalid_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic [1:0]          rresp_q, rresp_d;
  // Mux results and their output flops
  logic [NUM_PINS-1:0] mux_oe, mux_do, mux_up, mux_dn;
  logic [NUM_PINS-1:0] pin_oe_q, pin_out_q, pull_up_q, pull_dn_q;
  logic                irq_up_d, irq_dn_d, irq_act_d, irq_edge_d;
  logic                irq_up_q, irq_dn_q, irq_act_q, irq_edge_q;
  logic                wr_fire;
  logic                wr_ok, rd_ok;
  logic [2:0]          wr_port, rd_port;
  logic [1:0]          wr_sel, rd_sel;
  // Address decode: port blocks below the interrupt registers, word aligned
  always_comb begin
    wr_port = aw_addr_q[PORT_IDX_LSB +: 3];
    wr_sel  = aw_addr_q[REG_SEL_LSB +: 2];
    rd_port = s_axi_araddr[PORT_IDX_LSB +: 3];
    rd_sel  = s_axi_araddr[REG_SEL_LSB +: 2];
    wr_ok   = (aw_addr_q[7] == 1'b0) && (aw_addr_q[1:0] == 2'h0)
              && (32'(wr_port) < NUM_PORTS) && (wr_sel != SEL_READ);
    wr_ok   = wr_ok || (aw_addr_q == OFS_IRQ_CTRL);
    rd_ok   = (s_axi_araddr[7] == 1'b0) && (s_axi_araddr[1:0] == 2'h0)
              && (32'(rd_port) < NUM_PORTS);
    rd_ok   = rd_ok || (s_axi_araddr == OFS_IRQ_CTRL) || (s_axi_araddr == OFS_IRQ_STAT);
    port_view = (dir_q & data_q) | (~dir_q & pin_sync_q);
  end

  // Write channel: address and data taken in either order, reply once both held
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    data_d    = data_q;
    dir_d     = dir_q;
    pull_d    = pull_q;
    irq_ctrl_d = irq_ctrl_q;
    wr_fire   = aw_held_q && w_held_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      w_byte_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];   // Registers are one byte wide, lane 0 only
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wr_ok && w_lane_q) begin
        if (aw_addr_q == OFS_IRQ_CTRL) begin
          irq_ctrl_d = w_byte_q[2:0];
        end else begin
          case (wr_sel)
            SEL_DATA: data_d[32'(wr_port) * PORT_W +: PORT_W] = w_byte_q;
            SEL_DIR:  dir_d[32'(wr_port) * PORT_W +: PORT_W]  = w_byte_q;
            SEL_PULL: pull_d[32'(wr_port) * PORT_W +: PORT_W] = w_byte_q;
            default:  data_d = data_q;
          endcase
        end
      end
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // Read channel: one read at a time, answered the cycle after the address
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_d   = '0;
      if (s_axi_araddr == OFS_IRQ_CTRL) begin
        rdata_d[2:0] = irq_ctrl_q;
      end else if (s_axi_araddr == OFS_IRQ_STAT) begin
        rdata_d[0] = irq_sync_q;
      end else if (rd_ok) begin
        case (rd_sel)
          SEL_DATA: rdata_d[7:0] = data_q[32'(rd_port) * PORT_W +: PORT_W];
          SEL_DIR:  rdata_d[7:0] = dir_q[32'(rd_port) * PORT_W +: PORT_W];
          SEL_PULL: rdata_d[7:0] = pull_q[32'(rd_port) * PORT_W +: PORT_W];
          // Output bits read back the latch, input bits the pin, whoever owns it
          default:  rdata_d[7:0] = port_view[32'(rd_port) * PORT_W +: PORT_W];
        endcase
      end
    end
  end
  // One cell per pin; only four pins can turn their pull into a pulldown
  for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_pin
    pin_share_cell #(.PULLDN_OK(PULLDN_CAP[gi])) u_cell (
      .port_oe  (dir_q[gi]),
      .port_do  (data_q[gi]),
      .pull_bit (pull_q[gi]),
      .alt1_en  (alt1_en[gi]),
      .alt1_oe  (alt1_oe[gi]),
      .alt1_do  (alt1_out[gi]),
      .alt2_en  (alt2_en[gi]),
      .alt2_oe  (alt2_oe[gi]),
      .alt2_do  (alt2_out[gi]),
      .key_rise (key_interrupt_rise[gi]),
      .pin_oe   (mux_oe[gi]),
      .pin_do   (mux_do[gi]),
      .pull_up  (mux_up[gi]),
      .pull_dn  (mux_dn[gi])
    );
  end

  // Interrupt pin: level and edge only when enabled, pullup needs only PE; pull flips for rising sense only when enabled
  always_comb begin
    irq_dn_d   = irq_ctrl_q[IRQ_PE_BIT] & irq_ctrl_q[IRQ_EN_BIT]
                 & irq_ctrl_q[IRQ_RISE_BIT];
    irq_up_d   = irq_ctrl_q[IRQ_PE_BIT] & ~irq_dn_d;
    irq_act_d  = irq_ctrl_q[IRQ_EN_BIT]
                 & (irq_ctrl_q[IRQ_RISE_BIT] ? irq_sync_q : ~irq_sync_q);
    irq_edge_d = irq_ctrl_q[IRQ_EN_BIT]
                 & (irq_ctrl_q[IRQ_RISE_BIT] ? (irq_sync_q & ~irq_prev_q)
                                             : (~irq_sync_q & irq_prev_q));
  end

  // All state registered here; reset leaves pins as floating inputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_q     <= {NUM_PORTS{PORT_RESET}};
      dir_q      <= {NUM_PORTS{PORT_RESET}};
      pull_q     <= {NUM_PORTS{PORT_RESET}};
      irq_ctrl_q <= IRQ_RESET;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      irq_meta_q <= 1'b1;
      irq_sync_q <= 1'b1;
      irq_prev_q <= 1'b1;
      aw_held_q  <= 1'b0;
      aw_addr_q  <= '0;
      w_held_q   <= 1'b0;
      w_byte_q   <= '0;
      w_lane_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
      pin_oe_q   <= '0;
      pin_out_q  <= '0;
      pull_up_q  <= '0;
      pull_dn_q  <= '0;
      irq_up_q   <= 1'b0;
      irq_dn_q   <= 1'b0;
      irq_act_q  <= 1'b0;
      irq_edge_q <= 1'b0;
    end else begin
      data_q     <= data_d;
      dir_q      <= dir_d;
      pull_q     <= pull_d;
      irq_ctrl_q <= irq_ctrl_d;
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      irq_meta_q <= ext_irq_pin;
      irq_sync_q <= irq_meta_q;
      irq_prev_q <= irq_sync_q;
      aw_held_q  <= aw_held_d;
      aw_addr_q  <= aw_addr_d;
      w_held_q   <= w_held_d;
      w_byte_q   <= w_byte_d;
      w_lane_q   <= w_lane_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      arready_q  <= arready_d | (!rvalid_d && !arready_q && !rvalid_q);
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      pin_oe_q   <= mux_oe;
      pin_out_q  <= mux_do;
      pull_up_q  <= mux_up;
      pull_dn_q  <= mux_dn;
      irq_up_q   <= irq_up_d;
      irq_dn_q   <= irq_dn_d;
      irq_act_q  <= irq_act_d;
      irq_edge_q <= irq_edge_d;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign pin_oe           = pin_oe_q;
  assign pin_out          = pin_out_q;
  assign pin_pull_up      = pull_up_q;
  assign pin_pull_dn      = pull_dn_q;
  assign pin_level        = pin_sync_q;  // Synchronised level for the peripherals
  assign ext_irq_pull_up  = irq_up_q;
  assign ext_irq_pull_dn  = irq_dn_q;
  assign ext_irq_asserted = irq_act_q;
  assign ext_irq_edge     = irq_edge_q;
endmodule

// ==== logic/pin_mux_pkg.sv ====
// Constants shared by the pin sharing mux and its per-pin cell
package pin_mux_pkg;
  localparam int          NUM_PORTS    = 6;
  localparam int          PORT_W       = 8;
  localparam int          NUM_PINS     = NUM_PORTS * PORT_W;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  // Register map: one block of four words per port, ports B..G as index 0..5
  localparam int          PORT_IDX_LSB = 4;
  localparam int          REG_SEL_LSB  = 2;
  localparam logic [1:0]  SEL_DATA     = 2'h0;
  localparam logic [1:0]  SEL_DIR      = 2'h1;
  localparam logic [1:0]  SEL_PULL     = 2'h2;
  localparam logic [1:0]  SEL_READ     = 2'h3;
  localparam logic [7:0]  OFS_IRQ_CTRL = 8'h60;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h64;
  localparam int          IRQ_EN_BIT   = 0;
  localparam int          IRQ_RISE_BIT = 1;
  localparam int          IRQ_PE_BIT   = 2;
  localparam logic [7:0]  PORT_RESET   = 8'h00;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;
  // Pins whose pull device turns into a pulldown under rising key sense:
  // port D bits 7, 3, 2 and port G bit 4
  localparam logic [NUM_PINS-1:0] PULLDN_CAP = 48'h1000_008c_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== logic/pin_share_cell.sv ====
// One pin's owner selection and pull device choice
`timescale 1ns/1ns
module pin_share_cell #(
  parameter bit PULLDN_OK = 1'b0
) (
  input  wire logic port_oe,
  input  wire logic port_do,
  input  wire logic pull_bit,
  input  wire logic alt1_en,
  input  wire logic alt1_oe,
  input  wire logic alt1_do,
  input  wire logic alt2_en,
  input  wire logic alt2_oe,
  input  wire logic alt2_do,
  input  wire logic key_rise,
  output logic      pin_oe,
  output logic      pin_do,
  output logic      pull_up,
  output logic      pull_dn
);
  logic as_input;
  logic want_dn;

  // Highest enabled owner wins: second alternate, then first, then port
  always_comb begin
    if (alt2_en) begin
      pin_oe = alt2_oe;
      pin_do = alt2_do;
    end else if (alt1_en) begin
      pin_oe = alt1_oe;
      pin_do = alt1_do;
    end else begin
      pin_oe = port_oe;
      pin_do = port_do;
    end
  end

  // Pull device acts whenever the pin is an input, whoever owns it
  always_comb begin
    as_input = ~pin_oe;
    want_dn  = PULLDN_OK & alt1_en & ~alt2_en & key_rise;
    pull_up  = pull_bit & as_input & ~want_dn;
    pull_dn  = pull_bit & as_input & want_dn;
  end
endmodule

// ==== test/port_pin_sharing_mux_sva.sv ====
// Checker for owner choice and pull devices of the pin sharing mux
`timescale 1ns/1ns
module port_pin_sharing_mux_sva
  import pin_mux_pkg::*;
(
  input wire logic                             core_clk,
  input wire logic                             sys_rst,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pull_up,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pull_dn,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] alt1_en,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] alt1_oe,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_en,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_oe,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] alt2_out,
  input wire logic [pin_mux_pkg::NUM_PINS-1:0] key_interrupt_rise,
  input wire logic                             ext_irq_pull_up,
  input wire logic                             ext_irq_pull_dn,
  input wire logic                             ext_irq_asserted,
  input wire logic                             ext_irq_edge
);
  import pin_mux_pkg::*;
  logic [NUM_PINS-1:0] own1_q;
  logic [NUM_PINS-1:0] own2_q;
  // Owners one edge back, since pin outputs are registered once
  always_ff @(posedge core_clk) begin
    own1_q <= alt1_en & ~alt2_en;
    own2_q <= alt2_en;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> (pin_oe | pin_pull_up | pin_pull_dn) == '0)
    else $error("pins not idle after reset");
  chk_alt2_owns: assert property (
    !$past(sys_rst) |-> ((pin_oe ^ $past(alt2_oe)) & own2_q) == '0
      && ((pin_out ^ $past(alt2_out)) & own2_q & pin_oe) == '0)
    else $error("second alternate lost the pin");
  chk_alt1_owns: assert property (
    !$past(sys_rst) |-> ((pin_oe ^ $past(alt1_oe)) & own1_q) == '0)
    else $error("first alternate lost the pin");
  chk_pull_input: assert property (
    ((pin_pull_up | pin_pull_dn) & pin_oe) == '0)
    else $error("pull device on a driven pin");
  chk_pulldn_pins: assert property (
    (pin_pull_dn & ~PULLDN_CAP) == '0)
    else $error("pulldown on a pin without one");
  chk_key_no_pullup: assert property (
    !$past(sys_rst) |-> (pin_pull_up & own1_q & $past(key_interrupt_rise) & PULLDN_CAP) == '0)
    else $error("pullup under rising key sense");
  chk_irq_edge_level: assert property (
    ext_irq_edge |-> ext_irq_asserted)
    else $error("irq edge without active level");
  chk_irq_pull_one: assert property (
    !(ext_irq_pull_up && ext_irq_pull_dn))
    else $error("irq pullup and pulldown together");
endmodule

bind port_pin_sharing_mux port_pin_sharing_mux_sva port_pin_sharing_mux_sva_i (
  .core_clk, .sys_rst, .pin_oe, .pin_out, .pin_pull_up, .pin_pull_dn, .alt1_en, .alt1_oe,
  .alt2_en, .alt2_oe, .alt2_out, .key_interrupt_rise, .ext_irq_pull_up, .ext_irq_pull_dn,
  .ext_irq_asserted, .ext_irq_edge);

// ==== test/pin_board_model.sv ====
// Board side of the shared pins: external drivers, pull resistors, floating lines
`timescale 1ns/1ns
module pin_board_model
  import pin_mux_pkg::*;
(
  input  wire logic                             core_clk,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pull_up,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_pull_dn,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_drive,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_val,
  output logic      [pin_mux_pkg::NUM_PINS-1:0] pin_in
);
  import pin_mux_pkg::*;
  logic [NUM_PINS-1:0] last_q = '0;
  // An undriven, unpulled line toggles so a missing pull never reads as settled
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_val)
                | (~pin_oe & ~ext_drive & (pin_pull_up | (~pin_pull_dn & ~last_q)));
  always @(posedge core_clk) begin
    last_q <= pin_in;
  end
endmodule

// ==== test/port_pin_sharing_mux_bench.sv ====
// Self-checking bench for the port pin sharing mux
`timescale 1ns/1ns
module port_pin_sharing_mux_bench;
  import pin_mux_pkg::*;
  logic                core_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0]   s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_irq_pin = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [NUM_PINS-1:0] alt1_en = '0, alt1_oe = '0, alt1_out = '0, key_interrupt_rise = '0;
  logic [NUM_PINS-1:0] alt2_en = '0, alt2_oe = '0, alt2_out = '0;
  logic [NUM_PINS-1:0] ext_drive = 48'hf0, ext_val = 48'h30;
  logic [NUM_PINS-1:0] pin_in, pin_oe, pin_out, pin_pull_up, pin_pull_dn, pin_level;
  logic                ext_irq_pull_up, ext_irq_pull_dn, ext_irq_asserted, ext_irq_edge;
  int                  bad_count = 0, cmp_count = 0, n;

  port_pin_sharing_mux port_pin_sharing_mux_i (
    .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .pin_oe, .pin_out, .pin_pull_up, .pin_pull_dn, .pin_level,
    .alt1_en, .alt1_oe, .alt1_out, .alt2_en, .alt2_oe, .alt2_out, .key_interrupt_rise,
    .ext_irq_pin, .ext_irq_pull_up, .ext_irq_pull_dn, .ext_irq_asserted, .ext_irq_edge);
  pin_board_model pin_board_model_i (
    .core_clk, .pin_oe, .pin_out, .pin_pull_up, .pin_pull_dn, .ext_drive, .ext_val, .pin_in);

  always #20 core_clk = ~core_clk;

  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Lets k edges pass, then samples once the edge updates have landed
  task automatic pause(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    s_axi_bready <= 1'b0;
    check("bvalid", 48'(s_axi_bvalid), 48'h1);  // A lost answer must not pass
    check("bresp", 48'(s_axi_bresp), 48'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    s_axi_rready <= 1'b0;
    check("rvalid", 48'(s_axi_rvalid), 48'h1);  // A lost answer must not pass
    check("rdata", 48'(s_axi_rdata), 48'(ed));
    check("rresp", 48'(s_axi_rresp), 48'(er));
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #(40 * 3000);
    bad_count++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    pause(1);
    check("oe", pin_oe, '0);
    check("pull", pin_pull_up | pin_pull_dn, '0);
    rd(8'h04, 32'h0, RESP_OKAY);
    $display("reset test done");
    // Port B low nibble as outputs, high nibble driven by the board
    wr(8'h00, 32'ha5, RESP_OKAY);
    wr(8'h04, 32'h0f, RESP_OKAY);
    pause(2);
    check("oe", pin_oe, 48'h0f);
    check("out", pin_out & pin_oe, 48'h05);
    rd(8'h0c, 32'h35, RESP_OKAY);
    check("level", pin_level & 48'hff, 48'h35);
    @(posedge core_clk);
    alt1_en <= 48'h0f;
    alt1_oe <= 48'h02;
    alt1_out <= 48'h02;
    alt2_en <= 48'h01;
    alt2_oe <= 48'h01;
    pause(2);
    check("oe", pin_oe, 48'h03);
    check("out", pin_out & pin_oe, 48'h02);
    rd(8'h0c, 32'h35, RESP_OKAY);
    $display("owner test done");
    @(posedge core_clk);
    alt1_en <= '0; // Every sharer released before a new owner comes
    alt2_en <= '0;
    wr(8'h28, 32'hff, RESP_OKAY);
    wr(8'h58, 32'h10, RESP_OKAY);
    @(posedge core_clk);
    alt1_en <= 48'h1000_00c4_0000;
    key_interrupt_rise <= 48'h1000_00c0_0000;
    pause(2);
    check("pull_dn", pin_pull_dn, 48'h1000_0080_0000);
    check("pull_up", pin_pull_up, 48'h0000_007f_0000);
    @(posedge core_clk);
    alt2_en <= 48'h0000_0080_0000;
    pause(2);
    check("pull_dn", pin_pull_dn, 48'h1000_0000_0000);
    @(posedge core_clk);
    alt1_en <= '0;
    alt2_en <= '0;
    wr(8'h24, 32'h01, RESP_OKAY);
    pause(2);
    check("pull_up", pin_pull_up, 48'h1000_00fe_0000);
    check("oe", pin_oe, 48'h0000_0001_000f);
    $display("pull test done");
    @(posedge core_clk);
    ext_irq_pin <= 1'b1;
    pause(4);
    check("irq", {ext_irq_asserted, ext_irq_pull_up, ext_irq_pull_dn}, 48'h0);
    rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(OFS_IRQ_CTRL, 32'h7, RESP_OKAY); // Only edges after enabling are trusted
    pause(2);
    check("irq_pull", {ext_irq_pull_up, ext_irq_pull_dn}, 48'h1);
    @(posedge core_clk);
    ext_irq_pin <= 1'b0;
    pause(4);
    check("irq_level", ext_irq_asserted, 48'h0);
    @(posedge core_clk);
    ext_irq_pin <= 1'b1;
    n = 0;
    while (ext_irq_edge !== 1'b1 && n < 8) begin
      pause(1);
      n++;
    end
    check("irq_edge", {ext_irq_edge, ext_irq_asserted}, 48'h3);
    wr(OFS_IRQ_CTRL, 32'h5, RESP_OKAY);
    pause(2);
    check("irq_pull", {ext_irq_pull_up, ext_irq_pull_dn}, 48'h2);
    $display("irq test done");
    wr(8'h70, 32'hff, RESP_SLVERR);
    rd(8'h70, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'h00, RESP_SLVERR);
    rd(8'h0c, 32'h35, RESP_OKAY);
    // Lane 0 strobe low: accepted but the data latch keeps its value
    s_axi_wstrb <= 4'he;
    wr(8'h00, 32'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(8'h00, 32'ha5, RESP_OKAY);
    $display("bus error test done");
    give_verdict();
  end
endmodule
